// >>> hw/bit_time_arbiter_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the arbiter.
// Assumes: 32-bit AXI4-Lite register words, one per register.
// Notes: Definitions only.
`ifndef BIT_TIME_ARBITER_CONSTS_SVH
`define BIT_TIME_ARBITER_CONSTS_SVH

`define OFS_CTRL 4'h0
`define OFS_COUNT 4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK 4'hc

`define BIT_MODE_LO 0
`define BIT_MODE_HI 1
`define BIT_CLK_SEL 2
`define BIT_COUNT_MSB 3
`define BIT_OVERFLOW 4
`define BIT_RUNNING 5
`define BIT_LOST 6
`define BIT_DONE 7

`define IRQ_DONE 0
`define IRQ_OVERFLOW 1
`define IRQ_LOST 2
`define IRQ_WIDTH 3

`define CTRL_RESET 8'h00
`define PRE_DIV 2'h3
`define SAMPLE_AT_BUS 9'h038
`define SAMPLE_AT_PRE 9'h008
`define COUNT_MAX 9'h1ff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> hw/bit_time_arbiter_pkg.sv
// Purpose: Types shared by the arbiter design.
// Assumes: Nothing beyond the constants header.
// Notes: Mode codes follow the two-bit mode field.
package bit_time_arbiter_pkg;
  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_MEASURE = 2'h1,
    MODE_ARBITRATE = 2'h2,
    MODE_RESERVED = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    ST_STOPPED = 2'h0,
    ST_WAIT = 2'h1,
    ST_RUN = 2'h3,
    ST_DONE = 2'h2
  } meas_state_t;
endpackage : bit_time_arbiter_pkg

// >>> hw/bit_time_arbiter.sv
// Purpose: Serial bit time measurement and bus arbitration counter.
// Assumes: rx_line, tx_internal and prescale_tick are synchronous to aclk.
// Notes: Registers are reached over AXI4-Lite, one aligned word each.
// Functional notes
// [RULE1] Done flag sets when measurement completes; any control write clears it.
// [RULE2] Running flag reads one while counting, zero when stopped.
// [RULE3] Overflow flag sets on counter overflow; any control write clears it.
// [RULE4] Mode 00 holds the counter reset and idle.
// [RULE5] Counter bit 8 readable in control; control write and reset clear it.
// [RULE6] Counter low eight bits readable in data register; control write clears.
// [RULE7] Clock select 0: bus clock/4, count between two rx falling edges.
// [RULE8] Running while counting; done set on second falling edge.
// [RULE9] Clock select 1: prescaler/4, start when rx sampled low.
// [RULE10] Rx already low on enable starts counting at once.
// [RULE11] Break measurement stops on next rx rising edge.
// [RULE12] Mode 10 arbitrates; counter restarts on each transmitter rising edge.
// [RULE13] Sample rx once at 0x38 or 0x08; low sets arbitration lost.
// [RULE14] While arbitration lost, transmit pin is forced high.
// [RULE15] Transmitter low before a low rx sample resets the counter.
// [RULE16] Mode 00 idle, 01 measure, 10 arbitrate, 11 reserved; reset clears.
// [RULE17] Writing zero to upper mode bit clears arbitration lost.
// [RULE18] Clock select bit picks prescaler/4 or bus/4; reset clears it.
// [RULE19] Overflow raised when counter increments past 0x1ff.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`include "bit_time_arbiter_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module bit_time_arbiter
  import bit_time_arbiter_pkg::*;
(
  input wire logic aclk, // 20 MHz bus clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [3:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [3:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic rx_line, // Receive line level
  input wire logic tx_internal, // Transmitter output before gating
  input wire logic prescale_tick, // One-cycle pulse from serial prescaler
  output logic tx_pin, // Transmit pin level
  output logic irq // Level interrupt, high while unmasked event pending
);

  logic [7:0] ctrl_q;
  logic [8:0] count_q;
  logic overflow_q;
  logic done_q;
  logic lost_q;
  logic sampled_q;
  logic [1:0] div_q;
  logic rx_q;
  logic tx_q;
  logic [`IRQ_WIDTH-1:0] irq_status_q;
  logic [`IRQ_WIDTH-1:0] irq_mask_q;
  meas_state_t meas_q;
  logic arb_run_q;
  logic aw_held_q;
  logic w_held_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  mode_t mode;
  logic clk_sel;
  logic tick;
  logic rx_fall;
  logic rx_rise;
  logic tx_rise;
  logic running;
  logic wr_go;
  logic ctrl_wr;
  logic lost_set;
  logic done_set;
  logic ovf_set;
  logic [8:0] sample_at;

  // Byte-lane merge for the low byte, the only byte with writable bits.
  function automatic logic [7:0] merge_low(input logic [7:0] old_v,
                                           input logic [31:0] data,
                                           input logic [3:0] strb);
    merge_low = strb[0] ? data[7:0] : old_v;
  endfunction : merge_low

  assign mode = mode_t'(ctrl_q[`BIT_MODE_HI:`BIT_MODE_LO]);
  assign clk_sel = ctrl_q[`BIT_CLK_SEL];
  assign rx_fall = rx_q & ~rx_line;
  assign rx_rise = ~rx_q & rx_line;
  assign tx_rise = ~tx_q & tx_internal;
  assign running = (meas_q == ST_RUN) | arb_run_q;
  assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign ctrl_wr = wr_go & (aw_addr_q == `OFS_CTRL);
  assign sample_at = clk_sel ? `SAMPLE_AT_PRE : `SAMPLE_AT_BUS;

  // Divide by four of the selected source. [RULE7] [RULE9] [RULE18]
  // The divider runs free in any active mode, so the first count of a
  // measurement can come up to three source periods early, never late.
  // This costs one count of resolution but needs no restart logic.
  assign tick = (div_q == `PRE_DIV) & (clk_sel ? prescale_tick : 1'b1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= 2'h0;
    else if (mode == MODE_IDLE)
      div_q <= 2'h0;
    else if (!clk_sel || prescale_tick)
      div_q <= div_q + 2'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_q <= 1'b1;
      tx_q <= 1'b1;
    end
    else
    begin
      rx_q <= rx_line;
      tx_q <= tx_internal;
    end
  end

  // Control: mode and clock select writable; reserved mode 11 is kept. [RULE16]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= `CTRL_RESET;
    else if (ctrl_wr)
      ctrl_q <= merge_low(ctrl_q, w_data_q, w_strb_q) & 8'h07;
  end

  // Measurement sequencer.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      meas_q <= ST_STOPPED;
    else if (ctrl_wr || mode != MODE_MEASURE)
      meas_q <= ST_STOPPED; // [RULE4]
    else
    begin
      unique case (meas_q)
        ST_STOPPED:
          meas_q <= ST_WAIT;
        ST_WAIT:
          if (!clk_sel && rx_fall)
            meas_q <= ST_RUN; // [RULE7]
          else if (clk_sel && !rx_line)
            meas_q <= ST_RUN; // [RULE9] [RULE10]
        ST_RUN:
          if ((!clk_sel && rx_fall) || (clk_sel && rx_rise))
            meas_q <= ST_DONE; // [RULE8] [RULE11]
        ST_DONE:
          meas_q <= ST_DONE;
      endcase
    end
  end

  assign done_set = (meas_q == ST_RUN) & (mode == MODE_MEASURE) & ~ctrl_wr &
    ((!clk_sel && rx_fall) || (clk_sel && rx_rise));

  // Arbitration run state and single sample per bit.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arb_run_q <= 1'b0;
      sampled_q <= 1'b0;
    end
    else if (mode != MODE_ARBITRATE || ctrl_wr)
    begin
      arb_run_q <= 1'b0;
      sampled_q <= 1'b0;
    end
    else if (tx_rise)
    begin
      arb_run_q <= 1'b1; // [RULE12]
      sampled_q <= 1'b0;
    end
    else if (!tx_internal && !lost_q && !lost_set)
    begin
      arb_run_q <= 1'b0; // [RULE15]
      sampled_q <= 1'b0;
    end
    else if (arb_run_q && count_q == sample_at && !sampled_q)
      sampled_q <= 1'b1; // [RULE13]
  end

  assign lost_set = (mode == MODE_ARBITRATE) & arb_run_q & ~sampled_q &
    (count_q == sample_at) & ~rx_line & ~tx_rise; // [RULE13]

  // Counter. Restart on transmitter edge reloads zero. [RULE4] [RULE12]
  assign ovf_set = running & tick & (count_q == `COUNT_MAX) & ~ctrl_wr; // [RULE19]

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= 9'h000;
    else if (ctrl_wr || mode == MODE_IDLE)
      count_q <= 9'h000; // [RULE5] [RULE6]
    else if (mode == MODE_ARBITRATE &&
             (tx_rise || (!tx_internal && !lost_q && !lost_set)))
      count_q <= 9'h000; // [RULE15]
    else if (mode == MODE_MEASURE && meas_q == ST_STOPPED)
      count_q <= 9'h000;
    else if (running && tick)
      count_q <= count_q + 9'h001;
  end

  // Overflow and done flags: a control write blocks the set in its own cycle, so clear wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overflow_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      overflow_q <= ovf_set | (overflow_q & ~ctrl_wr); // [RULE3]
      done_q <= done_set | (done_q & ~ctrl_wr); // [RULE1]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lost_q <= 1'b0;
    else if (lost_set)
      lost_q <= 1'b1;
    else if (ctrl_wr && w_strb_q[0] && !w_data_q[`BIT_MODE_HI])
      lost_q <= 1'b0; // [RULE17]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_pin <= 1'b1;
    else
      // Folding in the set term keeps the pin from glitching low in the
      // cycle in which arbitration is lost.
      tx_pin <= tx_internal | lost_q | lost_set; // [RULE14]
  end

  // Interrupt status, write one to clear; events win over clears.
  logic irq_wr;
  logic [`IRQ_WIDTH-1:0] irq_evt;
  assign irq_wr = wr_go & (aw_addr_q == `OFS_IRQ_STATUS) & w_strb_q[0];
  assign irq_evt = {lost_set, ovf_set, done_set};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status_q <= '0;
    else if (irq_wr)
      irq_status_q <= (irq_status_q & ~w_data_q[`IRQ_WIDTH-1:0]) | irq_evt;
    else
      irq_status_q <= irq_status_q | irq_evt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_q <= '0;
    else if (wr_go && aw_addr_q == `OFS_IRQ_MASK && w_strb_q[0])
      irq_mask_q <= w_data_q[`IRQ_WIDTH-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status_q & irq_mask_q);
  end

  // AXI write: address and data taken in either order, response after both.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q == `OFS_COUNT || aw_addr_q[1:0] != 2'h0) ?
          `RESP_SLVERR : `RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read: one cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        unique case (s_axi_araddr)
          `OFS_CTRL:
            s_axi_rdata <= {24'h0, done_q, lost_q, running, overflow_q,
                            count_q[8], ctrl_q[2:0]}; // [RULE2] [RULE5]
          `OFS_COUNT:
            s_axi_rdata <= {24'h0, count_q[7:0]}; // [RULE6]
          `OFS_IRQ_STATUS:
            s_axi_rdata <= {29'h0, irq_status_q};
          `OFS_IRQ_MASK:
            s_axi_rdata <= {29'h0, irq_mask_q};
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : bit_time_arbiter

`default_nettype wire

// >>> sim/bit_time_arbiter_props.sv
// Purpose: Port-level checks on the bit time arbiter.
// Assumes: One clock domain; reset is synchronous and active low.
// Notes: Bound to the design top after the module.
`timescale 1ns/100ps
`default_nettype none
module bit_time_arbiter_props (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic s_axi_awvalid, // Address valid
  input wire logic s_axi_awready, // Address ready
  input wire logic s_axi_wvalid, // Data valid
  input wire logic s_axi_wready, // Data ready
  input wire logic s_axi_bvalid, // Response valid
  input wire logic s_axi_bready, // Response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read valid
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic tx_internal, // Transmitter output
  input wire logic tx_pin // Transmit pin
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  wr_busy_a: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write ready stayed high");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read data not on time");
  rd_busy_a: assert property (s_axi_arvalid && s_axi_arready
    |=> !s_axi_arready)
    else $error("read ready stayed high");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  tx_high_a: assert property (tx_internal |=> tx_pin)
    else $error("transmit pin low after high transmitter");
  tx_fall_a: assert property ($fell(tx_pin) |-> !$past(tx_internal))
    else $error("transmit pin fell without transmitter low");
endmodule : bit_time_arbiter_props
bind bit_time_arbiter bit_time_arbiter_props props (.*);
`default_nettype wire

// >>> sim/serial_line_model.sv
// Purpose: Shared serial line and prescaler seen by the arbiter.
// Assumes: Wired-AND line with a pull-up; the other node pulls it low.
// Notes: Behavioural; ticks run only while the bench enables them.
`timescale 1ns/100ps
`default_nettype none
module serial_line_model (
  input wire logic tx_pin, // Our transmit pin
  input wire logic other_low, // Other node drives dominant
  input wire logic tick_en, // Prescaler running
  output logic rx_line, // Line level at receiver
  output logic prescale_tick // Prescaler pulse
);
  // Either node can pull the line low, so arbitration losses are real.
  assign rx_line = tx_pin & ~other_low;
  assign prescale_tick = tick_en;
endmodule : serial_line_model
`default_nettype wire

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the bit time arbiter.
// Assumes: The line model stands for the bus and the prescaler.
// Notes: Bus answers are queued as notes and checked by a monitor.
`include "bit_time_arbiter_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench
  import bit_time_arbiter_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_pin, irq, rx_line, prescale_tick;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic tx_internal = 1'b1, other_low = 1'b0, tick_en = 1'b0;
  logic [33:0] exp_q[$];
  logic [33:0] note;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, k, t0;
  int seed = 32'ha170;

  bit_time_arbiter DUT (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rx_line(rx_line),
    .tx_internal(tx_internal),
    .prescale_tick(prescale_tick),
    .tx_pin(tx_pin),
    .irq(irq)
  );
  serial_line_model far_side (
    .tx_pin(tx_pin),
    .other_low(other_low),
    .tick_en(tick_en),
    .rx_line(rx_line),
    .prescale_tick(prescale_tick)
  );

  always #25 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  task automatic close_out();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [33:0] e, s);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic guard(input int n);
    if (n >= 200)
    begin
      n_mismatch++;
      close_out();
    end
  endtask : guard

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] r = `RESP_OKAY);
    int n;
    logic ao, wo;
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    {ao, wo} = 2'b11;
    n = 0;
    do
    begin
      @(posedge aclk);
      guard(++n);
      if (ao && s_axi_awready === 1'b1)
      begin
        ao = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wo && s_axi_wready === 1'b1)
      begin
        wo = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] r = `RESP_OKAY);
    int n;
    logic ao;
    exp_q.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ao = 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      guard(++n);
      if (ao && s_axi_arready === 1'b1)
      begin
        ao = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  // A short low pulse on the line gives exactly one falling edge.
  task automatic fall(input int at);
    while (cyc < at)
      @(posedge aclk);
    other_low <= 1'b1;
    repeat (2) @(posedge aclk);
    other_low <= 1'b0;
  endtask : fall

  task automatic brk(input int n, input logic [31:0] c, v);
    other_low <= 1'b1;
    wr(`OFS_CTRL, 32'h5);
    rd(`OFS_CTRL, 32'h25);
    tick_en <= 1'b1;
    repeat (4 * n) @(posedge aclk);
    tick_en <= 1'b0;
    other_low <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(`OFS_CTRL, c);
    rd(`OFS_COUNT, v);
  endtask : brk

  task automatic arb(input logic [31:0] c, input int quiet, input logic lost);
    tx_internal <= 1'b0;
    wr(`OFS_CTRL, c);
    tx_internal <= 1'b1;
    repeat (quiet) @(posedge aclk);
    other_low <= 1'b1;
    repeat (300 - quiet) @(posedge aclk);
    other_low <= 1'b0;
    tx_internal <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("tx pin", lost, tx_pin);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_CTRL, 32'h0);
    chk("tx pin", 1'b0, tx_pin);
    tx_internal <= 1'b1;
  endtask : arb

  always @(posedge aclk)
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
    begin
      note = exp_q.pop_front();
      chk("bus answer", note, s_axi_rvalid ? {s_axi_rresp, s_axi_rdata}
        : {s_axi_bresp, 32'h0});
    end

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd(4'(4 * i), 32'h0);
    rd(4'h2, 32'h0, `RESP_SLVERR);
    wr(`OFS_COUNT, 32'hff, `RESP_SLVERR);
    rd(`OFS_COUNT, 32'h0);
    k = 4 + ($random(seed) & 31);
    wr(`OFS_IRQ_MASK, 32'h1);
    wr(`OFS_CTRL, 32'h1);
    t0 = cyc + 2;
    fall(t0);
    rd(`OFS_CTRL, 32'h21);
    fall(t0 + 4 * k);
    repeat (4) @(posedge aclk);
    chk("irq", 1'b1, irq);
    rd(`OFS_CTRL, 32'h81);
    rd(`OFS_COUNT, k);
    wr(`OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq", 1'b0, irq);
    wr(`OFS_CTRL, 32'h1);
    rd(`OFS_CTRL, 32'h1);
    rd(`OFS_COUNT, 32'h0);
    brk(k, 32'h85, k);
    brk(256, 32'h8d, 32'h0);
    brk(515, 32'h95, 32'h3);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_COUNT, 32'h0);
    tick_en <= 1'b1;
    arb(32'h2, 0, 1'b1);
    arb(32'h2, 240, 1'b0);
    arb(32'h6, 0, 1'b1);
    arb(32'h6, 60, 1'b0);
    close_out();
  end
endmodule : testbench
`default_nettype wire
